// >>> core/nfot_host.sv
// What this block does
// - Program and erase to a block marked bad in an earlier cycle are refused, never issued.
// - No page is programmed more than 10 times before its block is erased.
// - To end a sequential read, chip select stays high beyond 100 ns.
// - Last address to first read strobe: 150 ns for identifier, 50 ns else.
// - Identifier read: 100 ns from chip select low to first read strobe.
`timescale 1ns/1ps
`default_nettype none
module nfot_host #(
   parameter int PROG_CYC = nfot_pkg::PROG_TIME_NS / nfot_pkg::CLK_NS,
   parameter int ERASE_CYC = nfot_pkg::ERASE_TIME_NS / nfot_pkg::CLK_NS,
   parameter int SUSP_CYC = nfot_pkg::SUSPEND_WAIT_NS / nfot_pkg::CLK_NS,
   parameter int RST_ERASE_CYC = nfot_pkg::RST_ERASE_NS / nfot_pkg::CLK_NS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire nfot_pkg::nfot_op_t cmd_op,
   input wire logic [21:0] cmd_addr,
   input wire logic [9:0] cmd_len,
   input wire logic spare_excl,
   // Program data
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   // Read data
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   // Bad block marking and result
   input wire logic mark_valid,
   input wire logic [8:0] mark_block,
   output logic done,
   output logic [1:0] err,
   output logic [9:0] valid_block_count,
   output logic below_min,
   // Flash pins
   output logic cle,
   output logic ale,
   output logic ce_n,
   output logic we_n,
   output logic out_strobe_n,
   output logic spare_mask_n,
   output logic wp_n,
   output logic [7:0] io_out,
   output logic io_oe,
   input wire logic [7:0] io_in,
   input wire logic ready_busy
);
   nfot_pkg::nfot_state_t state_reg;
   nfot_pkg::nfot_op_t op_reg, busy_op_reg;
   logic [21:0] addr_reg;
   logic [9:0] len_reg, col_reg, vcnt_reg;
   logic [1:0] step_reg, ph_reg, err_reg;
   logic [19:0] tmr_reg;
   logic cmd_ready_reg, wr_ready_reg, done_reg, below_reg, suspended_reg;
   logic cle_reg, ale_reg, ce_n_reg, we_n_reg, re_n_reg, se_reg, wp_n_reg, io_oe_reg;
   logic [7:0] io_out_reg, push_data_reg;
   logic push_reg, fifo_ready;
   logic [511:0] bad_reg;
   logic [3:0] pp_cnt [16384];
   logic [13:0] clr_idx_reg;
   logic [14:0] clr_left_reg;

   // Operation decode.
   wire logic is_prog = op_reg == nfot_pkg::OP_PROG;
   wire logic is_erase = op_reg == nfot_pkg::OP_ERASE;
   wire logic is_page = op_reg == nfot_pkg::OP_READ || op_reg == nfot_pkg::OP_SPARE;
   wire logic is_id = op_reg == nfot_pkg::OP_ID;
   wire logic is_status = op_reg == nfot_pkg::OP_STATUS;
   wire logic is_reader = is_page || is_id || is_status;
   wire logic [1:0] n_addr = (is_page || is_prog) ? 2'h3 : is_erase ? 2'h2 : {1'b0, is_id};
   wire logic [7:0] cmd1 = (op_reg == nfot_pkg::OP_SPARE) ? nfot_pkg::CMD_READ2 :
      is_prog ? nfot_pkg::CMD_LOAD : is_erase ? nfot_pkg::CMD_ERASE :
      (op_reg == nfot_pkg::OP_RESET) ? nfot_pkg::CMD_RESET : is_id ? nfot_pkg::CMD_ID :
      (op_reg == nfot_pkg::OP_SUSP) ? nfot_pkg::CMD_SUSP : is_status ? nfot_pkg::CMD_STATUS :
      (op_reg == nfot_pkg::OP_RESUME) ? nfot_pkg::CMD_CONFIRM : nfot_pkg::CMD_READ1;
   wire logic [7:0] cmd2 = is_prog ? nfot_pkg::CMD_PROG : nfot_pkg::CMD_CONFIRM;
   wire logic [7:0] row_lo = addr_reg[15:8];
   wire logic [7:0] row_hi = {2'b00, addr_reg[21:16]};
   wire logic [7:0] abyte = is_id ? 8'h00 : is_erase ? ((step_reg == 2'h0) ? row_lo : row_hi) :
      (step_reg == 2'h0) ? addr_reg[7:0] : (step_reg == 2'h1) ? row_lo : row_hi;
   wire nfot_pkg::nfot_state_t after_cmd = (n_addr != 2'h0) ? nfot_pkg::ST_ADDR :
      is_status ? nfot_pkg::ST_GAP : nfot_pkg::ST_WAITB;
   wire nfot_pkg::nfot_state_t after_addr = (is_prog && len_reg != 10'h000) ? nfot_pkg::ST_WDATA :
      (is_prog || is_erase) ? nfot_pkg::ST_CMD2 : is_id ? nfot_pkg::ST_GAP : nfot_pkg::ST_WAITB;
   wire logic [19:0] gap = is_id ? nfot_pkg::ID_GAP_CYC :
      is_status ? nfot_pkg::WHR_CYC : nfot_pkg::READ_GAP_CYC;
   wire logic [9:0] page_end = se_reg ? nfot_pkg::MAIN_LAST : nfot_pkg::SPARE_LAST;
   wire logic [9:0] page_start = (op_reg == nfot_pkg::OP_SPARE) ? nfot_pkg::SPARE_BASE : 10'h000;

   // Busy timeouts by operation; reset depends on what it may interrupt.
   wire logic [19:0] rst_lim = suspended_reg ? nfot_pkg::RST_SUSP_CYC :
      (busy_op_reg == nfot_pkg::OP_PROG) ? nfot_pkg::RST_PROG_CYC :
      (busy_op_reg == nfot_pkg::OP_ERASE || busy_op_reg == nfot_pkg::OP_RESUME) ?
      20'(RST_ERASE_CYC) : nfot_pkg::RST_READ_CYC;
   wire logic [19:0] lim = is_prog ? 20'(PROG_CYC) :
      (is_erase || op_reg == nfot_pkg::OP_RESUME) ? 20'(ERASE_CYC) :
      (op_reg == nfot_pkg::OP_SUSP) ? 20'(SUSP_CYC) :
      (op_reg == nfot_pkg::OP_RESET) ? rst_lim : nfot_pkg::PAGE_FETCH_CYC;

   // Command acceptance and refusal.
   wire logic acc = cmd_valid && cmd_ready_reg;
   wire logic [13:0] cmd_row = cmd_addr[21:8];
   wire logic [8:0] cmd_blk = cmd_addr[21:13];
   wire logic c_wr = cmd_op == nfot_pkg::OP_PROG || cmd_op == nfot_pkg::OP_ERASE;
   wire logic c_rd = cmd_op == nfot_pkg::OP_READ || cmd_op == nfot_pkg::OP_SPARE ||
      cmd_op == nfot_pkg::OP_ID || cmd_op == nfot_pkg::OP_STATUS;
   wire logic refuse = (c_wr && bad_reg[cmd_blk]) ||
      (cmd_op == nfot_pkg::OP_PROG && pp_cnt[cmd_row] >= nfot_pkg::PP_LIMIT) ||
      (c_rd && cmd_len == 10'h000);
   wire logic take = acc && !refuse;
   wire logic [9:0] start_col = (cmd_op == nfot_pkg::OP_SPARE) ?
      (nfot_pkg::SPARE_BASE | {6'h00, cmd_addr[3:0]}) : {2'b00, cmd_addr[7:0]};
   wire logic new_bad = mark_valid && mark_block != 9'h000 && !bad_reg[mark_block];

   assign cmd_ready = cmd_ready_reg;
   assign wr_ready = wr_ready_reg;
   assign done = done_reg;
   assign err = err_reg;
   assign valid_block_count = vcnt_reg;
   assign below_min = below_reg;
   assign cle = cle_reg;
   assign ale = ale_reg;
   assign ce_n = ce_n_reg;
   assign we_n = we_n_reg;
   assign out_strobe_n = re_n_reg;
   assign spare_mask_n = se_reg;
   assign wp_n = wp_n_reg;
   assign io_out = io_out_reg;
   assign io_oe = io_oe_reg;

   nfot_fifo2 #(.WIDTH(8)) u_rbuf (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_valid(push_reg),
      .in_ready(fifo_ready),
      .in_data(push_data_reg),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // Bad block table and the valid block tally.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bad_reg <= '0;
         vcnt_reg <= nfot_pkg::BLOCKS;
         below_reg <= 1'b0;
      end else begin
         if (new_bad) begin
            bad_reg[mark_block] <= 1'b1;
            vcnt_reg <= vcnt_reg - 10'h001;
         end
         below_reg <= vcnt_reg < nfot_pkg::MIN_VALID;
      end
   end

   // Partial program counts; cleared page by page after reset and erase.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         clr_idx_reg <= 14'h0000;
         clr_left_reg <= nfot_pkg::PAGES;
      end else if (take && cmd_op == nfot_pkg::OP_ERASE) begin
         clr_idx_reg <= {cmd_blk, 5'h00};
         clr_left_reg <= nfot_pkg::PAGES_PER_BLOCK;
      end else if (clr_left_reg != 15'h0000) begin
         clr_idx_reg <= clr_idx_reg + 14'h0001;
         clr_left_reg <= clr_left_reg - 15'h0001;
      end
   end

   // The table has no reset of its own, so commands wait until the walker has swept it.
   always_ff @(posedge core_clk) begin
      if (clr_left_reg != 15'h0000) begin
         pp_cnt[clr_idx_reg] <= 4'h0;
      end else if (take && cmd_op == nfot_pkg::OP_PROG) begin
         pp_cnt[cmd_row] <= pp_cnt[cmd_row] + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg <= nfot_pkg::ST_IDLE;
         op_reg <= nfot_pkg::OP_READ;
         busy_op_reg <= nfot_pkg::OP_READ;
         addr_reg <= 22'h00_0000;
         len_reg <= 10'h000;
         col_reg <= 10'h000;
         step_reg <= 2'h0;
         ph_reg <= 2'h0;
         tmr_reg <= 20'h0_0000;
         err_reg <= 2'h0;
         cmd_ready_reg <= 1'b0;
         wr_ready_reg <= 1'b0;
         done_reg <= 1'b0;
         suspended_reg <= 1'b0;
         cle_reg <= 1'b0;
         ale_reg <= 1'b0;
         ce_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         re_n_reg <= 1'b1;
         se_reg <= 1'b0;
         wp_n_reg <= 1'b0;
         io_out_reg <= 8'h00;
         io_oe_reg <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= 8'h00;
      end else begin
         done_reg <= 1'b0;
         push_reg <= 1'b0;
         cmd_ready_reg <= 1'b0;
         wr_ready_reg <= 1'b0;
         tmr_reg <= tmr_reg + 20'h0_0001;
         unique case (state_reg)
            nfot_pkg::ST_IDLE: begin
               cmd_ready_reg <= clr_left_reg == 15'h0000 && !acc;
               if (acc && refuse) begin
                  done_reg <= 1'b1;
                  err_reg <= 2'h1;
               end else if (take) begin
                  op_reg <= cmd_op;
                  addr_reg <= cmd_addr;
                  len_reg <= cmd_len;
                  col_reg <= start_col;
                  err_reg <= 2'h0;
                  se_reg <= spare_excl && cmd_op != nfot_pkg::OP_SPARE;
                  wp_n_reg <= c_wr || cmd_op == nfot_pkg::OP_RESUME;
                  ce_n_reg <= 1'b0;
                  ph_reg <= 2'h0;
                  state_reg <= nfot_pkg::ST_CMD;
               end
            end
            nfot_pkg::ST_CMD, nfot_pkg::ST_CMD2: begin
               if (ph_reg == 2'h0) begin
                  cle_reg <= 1'b1;
                  ale_reg <= 1'b0;
                  io_out_reg <= (state_reg == nfot_pkg::ST_CMD) ? cmd1 : cmd2;
                  io_oe_reg <= 1'b1;
                  we_n_reg <= 1'b0;
                  ph_reg <= 2'h1;
               end else begin
                  we_n_reg <= 1'b1;
                  ph_reg <= 2'h0;
                  step_reg <= 2'h0;
                  tmr_reg <= 20'h0_0000;
                  state_reg <= (state_reg == nfot_pkg::ST_CMD) ? after_cmd : nfot_pkg::ST_WAITB;
               end
            end
            nfot_pkg::ST_ADDR: begin
               if (ph_reg == 2'h0) begin
                  cle_reg <= 1'b0;
                  ale_reg <= 1'b1;
                  io_out_reg <= abyte;
                  we_n_reg <= 1'b0;
                  ph_reg <= 2'h1;
               end else begin
                  we_n_reg <= 1'b1;
                  ph_reg <= 2'h0;
                  step_reg <= step_reg + 2'h1;
                  if (step_reg == n_addr - 2'h1) begin
                     tmr_reg <= 20'h0_0000;
                     wr_ready_reg <= after_addr == nfot_pkg::ST_WDATA;
                     state_reg <= after_addr;
                  end
               end
            end
            nfot_pkg::ST_WDATA: begin
               ale_reg <= 1'b0;
               if (ph_reg == 2'h0) begin
                  if (wr_valid && wr_ready_reg) begin
                     io_out_reg <= wr_data;
                     we_n_reg <= 1'b0;
                     ph_reg <= 2'h1;
                  end else begin
                     wr_ready_reg <= 1'b1;
                  end
               end else begin
                  we_n_reg <= 1'b1;
                  ph_reg <= 2'h0;
                  len_reg <= len_reg - 10'h001;
                  if (len_reg == 10'h001) begin
                     state_reg <= nfot_pkg::ST_CMD2;
                  end else begin
                     wr_ready_reg <= 1'b1;
                  end
               end
            end
            nfot_pkg::ST_WAITB: begin
               cle_reg <= 1'b0;
               ale_reg <= 1'b0;
               io_oe_reg <= 1'b0;
               // Ready is not trusted until busy has had time to assert.
               if (tmr_reg >= nfot_pkg::WB_CYC && tmr_reg >= nfot_pkg::RB_CYC && ready_busy) begin
                  tmr_reg <= 20'h0_0000;
                  busy_op_reg <= op_reg;
                  if (op_reg == nfot_pkg::OP_SUSP) begin
                     suspended_reg <= 1'b1;
                  end else if (op_reg == nfot_pkg::OP_RESUME || op_reg == nfot_pkg::OP_RESET) begin
                     suspended_reg <= 1'b0;
                  end
                  if (is_reader) begin
                     state_reg <= nfot_pkg::ST_GAP;
                  end else begin
                     ce_n_reg <= 1'b1;
                     state_reg <= nfot_pkg::ST_HOLD;
                  end
               end else if (tmr_reg >= lim) begin
                  err_reg <= 2'h2;
                  ce_n_reg <= 1'b1;
                  tmr_reg <= 20'h0_0000;
                  state_reg <= nfot_pkg::ST_HOLD;
               end
            end
            nfot_pkg::ST_GAP: begin
               cle_reg <= 1'b0;
               ale_reg <= 1'b0;
               io_oe_reg <= 1'b0;
               if (tmr_reg >= gap) begin
                  ph_reg <= 2'h0;
                  state_reg <= nfot_pkg::ST_READ;
               end
            end
            nfot_pkg::ST_READ: begin
               // A strobe starts only with room in the buffer, so a stalled reader loses nothing.
               if (ph_reg == 2'h0) begin
                  if (fifo_ready && !push_reg) begin
                     re_n_reg <= 1'b0;
                     ph_reg <= 2'h1;
                  end
               end else if (ph_reg == 2'h1) begin
                  ph_reg <= 2'h2;
               end else begin
                  push_reg <= 1'b1;
                  push_data_reg <= io_in;
                  re_n_reg <= 1'b1;
                  ph_reg <= 2'h0;
                  len_reg <= len_reg - 10'h001;
                  col_reg <= col_reg + 10'h001;
                  tmr_reg <= 20'h0_0000;
                  if (len_reg == 10'h001) begin
                     ce_n_reg <= 1'b1;
                     state_reg <= nfot_pkg::ST_HOLD;
                  end else if (is_page && col_reg == page_end) begin
                     col_reg <= page_start;
                     state_reg <= nfot_pkg::ST_WAITB;
                  end
               end
            end
            nfot_pkg::ST_HOLD: begin
               ce_n_reg <= 1'b1;
               cle_reg <= 1'b0;
               ale_reg <= 1'b0;
               io_oe_reg <= 1'b0;
               if (tmr_reg >= nfot_pkg::HOLD_CYC && tmr_reg >= nfot_pkg::CRY_CYC) begin
                  done_reg <= 1'b1;
                  wp_n_reg <= 1'b0;
                  state_reg <= nfot_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> shared/nfot_pkg.sv
`default_nettype none
package nfot_pkg;

   localparam int CLK_NS = 25;

   // Host-side operation codes offered on the command port.
   typedef enum logic [3:0] {
      OP_READ   = 4'h0,
      OP_SPARE  = 4'h1,
      OP_PROG   = 4'h2,
      OP_ERASE  = 4'h3,
      OP_RESET  = 4'h4,
      OP_ID     = 4'h5,
      OP_SUSP   = 4'h6,
      OP_RESUME = 4'h7,
      OP_STATUS = 4'h8
   } nfot_op_t;

   // Sequencer states, Gray coded along the usual path up to ST_HOLD; ST_HOLD back to ST_IDLE changes two bits.
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_CMD   = 4'h1,
      ST_ADDR  = 4'h3,
      ST_WDATA = 4'h2,
      ST_CMD2  = 4'h6,
      ST_WAITB = 4'h7,
      ST_GAP   = 4'h5,
      ST_READ  = 4'h4,
      ST_HOLD  = 4'hC
   } nfot_state_t;

   localparam logic [7:0] CMD_READ1 = 8'h00;
   localparam logic [7:0] CMD_READ2 = 8'h50;
   localparam logic [7:0] CMD_ID = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_LOAD = 8'h80;
   localparam logic [7:0] CMD_PROG = 8'h10;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSP = 8'hB0;
   localparam logic [7:0] CMD_STATUS = 8'h70;

   localparam logic [9:0] BLOCKS = 10'h200;
   localparam logic [9:0] MIN_VALID = 10'h1F6;
   localparam logic [14:0] PAGES = 15'h4000;
   localparam logic [14:0] PAGES_PER_BLOCK = 15'h0020;
   localparam logic [3:0] PP_LIMIT = 4'hA;
   localparam logic [9:0] MAIN_LAST = 10'h1FF;
   localparam logic [9:0] SPARE_LAST = 10'h20F;
   localparam logic [9:0] SPARE_BASE = 10'h200;

   // Times as specified, in ns.
   localparam int PAGE_FETCH_TIME_NS = 10000;
   localparam int BUSY_ONSET_NS = 100;
   localparam int LAST_READ_TO_BUSY_NS = 100;
   localparam int INTERCEPT_READY_TIME_NS = 50;
   localparam int SELECT_HIGH_HOLD_NS = 100;
   localparam int ID_ADDR_TO_READ_GAP_NS = 150;
   localparam int ADDR_TO_READ_GAP_NS = 50;
   localparam int SELECT_TO_ID_READ_GAP_NS = 100;
   localparam int WRITE_TO_READ_GAP_NS = 60;
   localparam int READY_TO_READ_GAP_NS = 20;
   localparam int PROG_TIME_NS = 1500000;
   localparam int ERASE_TIME_NS = 10000000;
   localparam int SUSPEND_WAIT_NS = 500000;
   localparam int RST_READ_NS = 5000;
   localparam int RST_PROG_NS = 10000;
   localparam int RST_ERASE_NS = 500000;
   localparam int RST_SUSP_NS = 5000;

   // Longest times round down, least times round up.
   localparam logic [19:0] PAGE_FETCH_CYC = 20'(PAGE_FETCH_TIME_NS / CLK_NS);
   localparam logic [19:0] WB_CYC = 20'(BUSY_ONSET_NS / CLK_NS);
   localparam logic [19:0] RB_CYC = 20'(LAST_READ_TO_BUSY_NS / CLK_NS);
   localparam logic [19:0] CRY_CYC = 20'(INTERCEPT_READY_TIME_NS / CLK_NS);
   localparam logic [19:0] HOLD_CYC = 20'(SELECT_HIGH_HOLD_NS / CLK_NS + 1);
   localparam logic [19:0] AR1_CYC = 20'((ID_ADDR_TO_READ_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [19:0] AR2_CYC = 20'((ADDR_TO_READ_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [19:0] CR_CYC = 20'((SELECT_TO_ID_READ_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [19:0] WHR_CYC = 20'((WRITE_TO_READ_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [19:0] RR_CYC = 20'((READY_TO_READ_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [19:0] ID_GAP_CYC = (AR1_CYC > CR_CYC) ? AR1_CYC : CR_CYC;
   localparam logic [19:0] READ_GAP_CYC = (AR2_CYC > RR_CYC) ? AR2_CYC : RR_CYC;
   localparam logic [19:0] RST_READ_CYC = 20'(RST_READ_NS / CLK_NS);
   localparam logic [19:0] RST_PROG_CYC = 20'(RST_PROG_NS / CLK_NS);
   localparam logic [19:0] RST_SUSP_CYC = 20'(RST_SUSP_NS / CLK_NS);

endpackage
`default_nettype wire

// >>> core/nfot_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module nfot_fifo2 #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] head_reg, spare_reg;
   logic [1:0] cnt_reg;
   logic in_ready_reg, out_valid_reg;
   wire logic push = in_valid && in_ready_reg;
   wire logic pop = out_valid_reg && out_ready;
   wire logic [1:0] cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

   assign in_ready = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data = head_reg;

   // The head is always the oldest word, so the output never passes through a mux.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         head_reg <= '0;
         spare_reg <= '0;
         cnt_reg <= 2'h0;
         in_ready_reg <= 1'b0;
         out_valid_reg <= 1'b0;
      end else begin
         if (pop) begin
            head_reg <= (cnt_reg == 2'h2) ? spare_reg : in_data;
         end else if (push && cnt_reg == 2'h0) begin
            head_reg <= in_data;
         end
         if (push && (cnt_next == 2'h2)) begin
            spare_reg <= in_data;
         end
         cnt_reg <= cnt_next;
         in_ready_reg <= cnt_next != 2'h2;
         out_valid_reg <= cnt_next != 2'h0;
      end
   end
endmodule
`default_nettype wire

// >>> tb/nfot_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module nfot_flash_model (
   // Host pins
   input wire logic core_clk,
   input wire logic cle,
   input wire logic ale,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic out_strobe_n,
   input wire logic spare_mask_n,
   input wire logic [7:0] io_out,
   // Device answers
   output logic ready_busy,
   output logic [7:0] io_in
);
   // Every block here is good, so block zero and the valid count hold.
   logic [7:0] cmd_reg = 8'h00;
   logic [9:0] col_reg = 10'h000;
   logic [1:0] acnt_reg = 2'h0;
   logic [5:0] busy_reg = 6'h00;
   logic we_d = 1'b1;
   logic rs_d = 1'b1;
   wire logic is_rd = cmd_reg == 8'h00 || cmd_reg == 8'h50;
   // Spare mask high ends each page at 511 rather than 527.
   wire logic [9:0] last_col = spare_mask_n ? 10'h1FF : 10'h20F;
   wire logic [9:0] first_col = (cmd_reg == 8'h50) ? 10'h200 : 10'h000;
   wire logic [9:0] addr_col = (cmd_reg == 8'h50) ? {6'h20, io_out[3:0]} : {2'b00, io_out};
   assign ready_busy = (busy_reg == 6'h00);
   // Released bus shows the inverse so a late sample cannot pass.
   assign io_in = out_strobe_n ? ~(col_reg[7:0] + 8'h30) : col_reg[7:0] + 8'h30;
   always_ff @(posedge core_clk) begin
      we_d <= we_n;
      rs_d <= out_strobe_n;
      if (busy_reg != 6'h00) busy_reg <= busy_reg - 6'h01;
      if (out_strobe_n && !rs_d) begin
         col_reg <= (col_reg == last_col) ? first_col : col_reg + 10'h001;
         if (col_reg == last_col && is_rd) busy_reg <= 6'h14;
      end
      if (we_n && !we_d && cle) begin
         cmd_reg <= io_out;
         acnt_reg <= 2'h0;
         col_reg <= 10'h000;
         if (io_out inside {8'h10, 8'hD0, 8'hFF, 8'hB0}) busy_reg <= 6'h14;
      end else if (we_n && !we_d && ale) begin
         acnt_reg <= acnt_reg + 2'h1;
         if (acnt_reg == 2'h0) col_reg <= addr_col;
         if (acnt_reg == 2'h2 && is_rd) busy_reg <= 6'h14;
      end
      // A read is dropped on deselect, while program and erase run on.
      if (ce_n && is_rd) busy_reg <= 6'h00;
   end
endmodule
`default_nettype wire

// >>> tb/nfot_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nfot_chk (
   // Watched ports
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic cmd_ready,
   input wire logic done,
   input wire logic [1:0] err,
   input wire logic cle,
   input wire logic ale,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic out_strobe_n,
   input wire logic wp_n,
   input wire logic io_oe,
   input wire logic [7:0] io_out,
   input wire logic ready_busy,
   input wire logic [9:0] valid_block_count,
   input wire logic below_min
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   chk_latch_select_excl: assert property (!(cle && ale))
      else $error("cle and ale both high");
   chk_strobe_no_write: assert property (!out_strobe_n |-> we_n && !io_oe)
      else $error("read strobe with write");
   chk_busy_no_strobe: assert property (!ready_busy |-> out_strobe_n)
      else $error("strobe while busy");
   chk_select_hold: assert property ($rose(ce_n) |-> ce_n [*5])
      else $error("chip select hold short");
   chk_refuse_quiet: assert property (done && err == 2'b01 |-> ce_n && $past(ce_n))
      else $error("refusal moved pins");
   chk_wp_for_write: assert property (cle && !we_n && io_out inside {8'h60, 8'h80} |-> wp_n)
      else $error("write command with wp low");
   chk_done_ready: assert property (done |=> cmd_ready && !done)
      else $error("no ready after done");
   chk_floor_flag: assert property (below_min == ($past(valid_block_count) < 10'h01F6))
      else $error("floor flag wrong");
endmodule
bind nfot_host nfot_chk u_chk (.*);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk = 0, reset_n = 0, cmd_valid = 0, spare_excl = 0, wr_valid = 1, rd_ready = 1;
   logic mark_valid = 0, cmd_ready, wr_ready, rd_valid, done, below_min, cle, ale, ce_n, we_n;
   logic out_strobe_n, spare_mask_n, wp_n, io_oe, ready_busy;
   nfot_pkg::nfot_op_t cmd_op = nfot_pkg::OP_READ;
   logic [21:0] cmd_addr = 22'h00_0000;
   logic [9:0] cmd_len = 10'h001, valid_block_count;
   logic [7:0] wr_data = 8'hA5, rd_data, io_out, io_in;
   logic [8:0] mark_block = 9'h000;
   logic [1:0] err, e;
   int miscompares = 0, total_checks = 0, i;
   logic [7:0] rq[$];
   initial forever #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) rq.push_back(rd_data);
   nfot_host #(.PROG_CYC(50), .ERASE_CYC(50), .SUSP_CYC(50), .RST_ERASE_CYC(50)) dut (.*);
   nfot_flash_model u_flash (.*);
   task chk(input string n, input logic [9:0] x, input logic [9:0] s);
      total_checks++;
      if (s !== x) begin
         $display("[ERR] %s expected %h seen %h", n, x, s);
         miscompares++;
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task run(input nfot_pkg::nfot_op_t o, input logic [21:0] a, input logic [9:0] l);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 40000) begin @(negedge core_clk); n++; end
      cmd_op = o;
      cmd_addr = a;
      cmd_len = l;
      cmd_valid = 1;
      @(negedge core_clk);
      cmd_valid = 0;
      while (done !== 1'b1 && n < 44000) begin @(negedge core_clk); n++; end
      if (n >= 40000) begin miscompares++; conclude(); end
      e = err;
   endtask
   task t_read;
      rq.delete();
      rd_ready = 0;
      run(nfot_pkg::OP_READ, 22'h00_0000, 10'h002);
      chk("read stalled", 10'h000, 10'(rq.size()));
      rd_ready = 1;
      repeat (3) @(negedge core_clk);
      chk("read err", 10'h000, {8'h00, e});
      chk("read count", 10'h002, 10'(rq.size()));
      chk("read byte0", 10'h030, {2'b00, rq[0]});
      chk("read byte1", 10'h031, {2'b00, rq[1]});
      $display("t_read done");
   endtask
   task t_spare;
      rq.delete();
      spare_excl = 1;
      run(nfot_pkg::OP_SPARE, 22'h00_000E, 10'h003);
      spare_excl = 0;
      chk("spare err", 10'h000, {8'h00, e});
      chk("spare count", 10'h003, 10'(rq.size()));
      chk("spare first", 10'h03E, {2'b00, rq[0]});
      chk("spare wrap", 10'h030, {2'b00, rq[2]});
      $display("t_spare done");
   endtask
   task t_prog;
      for (i = 0; i < 11; i++) begin
         run(nfot_pkg::OP_PROG, 22'h00_4000, 10'h001);
         chk("prog err", (i == 10) ? 10'h001 : 10'h000, {8'h00, e});
      end
      run(nfot_pkg::OP_ERASE, 22'h00_4000, 10'h000);
      chk("erase err", 10'h000, {8'h00, e});
      run(nfot_pkg::OP_PROG, 22'h00_4000, 10'h001);
      chk("reprog err", 10'h000, {8'h00, e});
      $display("t_prog done");
   endtask
   task t_bad(input logic [8:0] b, input logic [9:0] cnt, input logic [1:0] x);
      mark_block = b;
      mark_valid = 1;
      @(negedge core_clk);
      mark_valid = 0;
      repeat (2) @(negedge core_clk);
      chk("valid count", cnt, valid_block_count);
      run(nfot_pkg::OP_ERASE, {b, 13'h0000}, 10'h000);
      chk("bad erase err", {8'h00, x}, {8'h00, e});
      $display("t_bad done");
   endtask
   task t_misc;
      run(nfot_pkg::OP_READ, 22'h00_0000, 10'h000);
      chk("zero len err", 10'h001, {8'h00, e});
      run(nfot_pkg::OP_SUSP, 22'h00_0000, 10'h000);
      chk("suspend err", 10'h000, {8'h00, e});
      run(nfot_pkg::OP_RESUME, 22'h00_0000, 10'h000);
      chk("resume err", 10'h000, {8'h00, e});
      run(nfot_pkg::OP_RESET, 22'h00_0000, 10'h000);
      chk("reset err", 10'h000, {8'h00, e});
      run(nfot_pkg::OP_ID, 22'h00_0000, 10'h002);
      chk("id err", 10'h000, {8'h00, e});
      run(nfot_pkg::OP_STATUS, 22'h00_0000, 10'h001);
      chk("status err", 10'h000, {8'h00, e});
      $display("t_misc done");
   endtask
   task t_floor;
      for (i = 1; i < 12; i++) begin
         mark_block = 9'(i);
         mark_valid = 1;
         @(negedge core_clk);
      end
      mark_valid = 0;
      repeat (2) @(negedge core_clk);
      chk("floor count", 10'h1F5, valid_block_count);
      chk("floor flag", 10'h001, {9'h000, below_min});
      $display("t_floor done");
   endtask
   initial begin
      repeat (5) @(negedge core_clk);
      reset_n = 1;
      t_read();
      t_spare();
      t_prog();
      t_bad(9'h005, 10'h1FF, 2'b01);
      t_bad(9'h000, 10'h1FF, 2'b00);
      t_misc();
      t_floor();
      conclude();
   end
endmodule
`default_nettype wire
